// ==== design/arf_flags.sv ====
// arf_flags: result registers and status flags of a multi-channel converter
// assumes: converter core on the same clock gives a one-cycle end-of-conversion pulse
// with its channel and result; software uses the plain register port
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Function
// R1: data ready clears only on last-result read; channel result reads leave it.
// R2: each stored conversion updates channel and last result, raises data ready.
// R3: data ready rises only when a result is really stored.
// R4: channel result read of another channel never blocks data ready setting.
// R5: general overrun sets when a store finds data ready still high.
// R6: status read clears general overrun unless a new one occurs then.
// R7: general overrun still sets beside other-channel reads or disables.
// R8: channel overrun sets when its conversion ends with done still high.
// R9: status read clears channel overrun unless a new one occurs then.
// R10: channel or matching last-result read clears that channel's done flag.
// R11: a channel result read clears only that channel's done flag.
// R12: no done flag for a channel disabled during its conversion.
// R13: sleep is entered at the end of a conversion, start wakes core.
// R14: a set and a clear in one cycle: the set wins; o_sleep instead lets a start or sleep mode off win over a conversion end.
module arf_flags #(
   parameter int N_CHAN = arf_pkg::NUM_CHAN,
   parameter int DATA_W = arf_pkg::DATA_W
) (
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_rst,
   input  wire logic                      i_ce,
   input  wire logic [arf_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [arf_pkg::BUS_W-1:0] i_wdata,
   input  wire logic                      i_wr,
   input  wire logic                      i_rd,
   output logic      [arf_pkg::BUS_W-1:0] o_rdata,
   input  wire logic                      i_eoc,
   input  wire logic [$clog2(N_CHAN)-1:0] i_eoc_chan,
   input  wire logic [DATA_W-1:0]         i_eoc_data,
   output logic                           o_conv_start,
   output logic      [N_CHAN-1:0]         o_chan_en,
   output logic                           o_sleep,
   output logic                           o_irq
);
   localparam int CW = $clog2(N_CHAN);

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   logic              wr_q;
   logic              rd_q;
   logic              is_cdr;
   logic [CW-1:0]     cdr_idx;
   logic              rd_last;
   logic              rd_stat;
   logic [N_CHAN-1:0] rd_cdr;
   logic [N_CHAN-1:0] dis_now;
   logic              eoc_v;
   logic              chan_ok;
   logic              store;
   logic              new_govr;
   logic [N_CHAN-1:0] done;
   logic [N_CHAN-1:0] ovr;
   logic [N_CHAN-1:0] ovr_set;
   logic [DATA_W-1:0] result [N_CHAN];
   logic [DATA_W-1:0] last_data;
   logic [CW-1:0]     last_chan;
   logic              data_ready_flag;
   logic              govr;
   logic              sleep_mode;
   logic [arf_pkg::INT_W-1:0] int_stat;
   logic [arf_pkg::INT_W-1:0] int_en;
   logic [arf_pkg::INT_W-1:0] int_evt;
   logic [arf_pkg::BUS_W-1:0] next_rdata;
   logic [arf_pkg::BUS_W-1:0] status_word;

   assign wr_q    = i_ce && i_wr;
   assign rd_q    = i_ce && i_rd;
   assign is_cdr  = (i_addr[7:4] == arf_pkg::CDR_PAGE) && (i_addr[1:0] == 2'b00);
   assign cdr_idx = i_addr[arf_pkg::CDR_IDX_LSB +: CW];
   assign rd_last = rd_q && (i_addr == arf_pkg::OFS_LAST);
   assign rd_stat = rd_q && (i_addr == arf_pkg::OFS_STATUS);
   // a disable in the eoc cycle must drop that store, so it is decoded combinationally
   assign dis_now = (wr_q && (i_addr == arf_pkg::OFS_CHDIS)) ? i_wdata[N_CHAN-1:0] : '0;
   assign eoc_v   = i_ce && i_eoc;

   // R12: disabled channel result dropped
   // R3: store only for a live channel
   assign chan_ok = o_chan_en[i_eoc_chan] && !dis_now[i_eoc_chan];
   // R2: other channel disables do not block
   assign store   = eoc_v && chan_ok;
   // R5: new overrun on pending data
   // R7: independent of other reads or disables
   assign new_govr = store && data_ready_flag;

   // ------------------------------------------------------------
   // channels
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < N_CHAN; g++) begin : gen_chan
         logic ch_sel;
         logic ch_store;
         logic ch_hit;
         logic ch_clr;
         assign ch_sel   = (i_eoc_chan == CW'(g));
         assign ch_store = store && ch_sel;
         // R8: a same-cycle channel disable does not mask it, only the registered enable does
         assign ch_hit   = eoc_v && ch_sel && o_chan_en[g];
         // R11: clear only the addressed channel
         assign rd_cdr[g] = rd_q && is_cdr && (cdr_idx == CW'(g));
         // R10: last-result read clears its owner
         assign ch_clr   = rd_cdr[g] || (rd_last && (last_chan == CW'(g)));
         arf_chan_cell #(
            .DATA_W     (DATA_W)
         ) u_cell (
            .i_ref_clk  (i_ref_clk),
            .i_rst      (i_rst),
            .i_store    (ch_store),
            .i_hit      (ch_hit && i_ce),
            .i_data     (i_eoc_data),
            .i_rd_clear (ch_clr),
            .i_stat_rd  (rd_stat),
            .o_done     (done[g]),
            .o_ovr      (ovr[g]),
            .o_result   (result[g]),
            .o_ovr_set  (ovr_set[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // last result
   // ------------------------------------------------------------
   // R2: last result follows every store
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         last_data <= '0;
         last_chan <= '0;
      end else if (store) begin
         last_data <= i_eoc_data;
         last_chan <= i_eoc_chan;
      end
   end

   // ------------------------------------------------------------
   // global flags
   // ------------------------------------------------------------
   // R1: only last-result read clears
   // R4: channel reads never interfere
   // R14: store beats clear
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         data_ready_flag <= arf_pkg::RST_BIT;
      end else if (store) begin
         data_ready_flag <= 1'b1;
      end else if (rd_last) begin
         data_ready_flag <= 1'b0;
      end
   end

   // R6: status read clears general overrun
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         govr <= arf_pkg::RST_BIT;
      end else if (new_govr) begin
         govr <= 1'b1;
      end else if (rd_stat) begin
         govr <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // control
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_chan_en <= '0;
      end else if (wr_q && (i_addr == arf_pkg::OFS_CHEN)) begin
         o_chan_en <= o_chan_en | i_wdata[N_CHAN-1:0];
      end else if (wr_q && (i_addr == arf_pkg::OFS_CHDIS)) begin
         o_chan_en <= o_chan_en & ~i_wdata[N_CHAN-1:0];
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         sleep_mode <= arf_pkg::RST_BIT;
      end else if (wr_q && (i_addr == arf_pkg::OFS_MODE)) begin
         sleep_mode <= i_wdata[arf_pkg::MODE_SLEEP];
      end
   end

   // start is a one-cycle pulse to the core, frozen with the enable like all state
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_conv_start <= arf_pkg::RST_BIT;
      end else if (i_ce) begin
         o_conv_start <= wr_q && (i_addr == arf_pkg::OFS_CTRL) && i_wdata[arf_pkg::CTRL_START];
      end
   end

   // R13: sleep waits for a conversion end
   // an idle core never sleeps until software starts one more conversion
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_sleep <= arf_pkg::RST_BIT;
      end else if (i_ce) begin
         if (o_conv_start || !sleep_mode) begin
            o_sleep <= 1'b0;
         end else if (eoc_v) begin
            o_sleep <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   always_comb begin
      int_evt = '0;
      int_evt[arf_pkg::INT_STORE] = store;
      int_evt[arf_pkg::INT_GOVR]  = new_govr;
      int_evt[arf_pkg::INT_OVR]   = |ovr_set;
   end

   // R14: event beats write-one clear
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         int_stat <= '0;
      end else if (wr_q && (i_addr == arf_pkg::OFS_INT_CLR)) begin
         int_stat <= (int_stat & ~i_wdata[arf_pkg::INT_W-1:0]) | int_evt;
      end else begin
         int_stat <= int_stat | int_evt;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         int_en <= '0;
      end else if (wr_q && (i_addr == arf_pkg::OFS_INT_EN)) begin
         int_en <= i_wdata[arf_pkg::INT_W-1:0];
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= arf_pkg::RST_BIT;
      end else if (i_ce) begin
         o_irq <= |(int_stat & int_en);
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_comb begin
      status_word = arf_pkg::RST_WORD;
      status_word[arf_pkg::ST_DONE_LSB +: N_CHAN] = done;
      status_word[arf_pkg::ST_OVR_LSB +: N_CHAN]  = ovr;
      status_word[arf_pkg::ST_DATA_READY_FLAG] = data_ready_flag;
      status_word[arf_pkg::ST_GOVR] = govr;
   end

   always_comb begin
      next_rdata = arf_pkg::RST_WORD;
      if (is_cdr && (int'(cdr_idx) < N_CHAN)) begin
         next_rdata[DATA_W-1:0] = result[cdr_idx];
      end else begin
         unique case (i_addr)
            arf_pkg::OFS_MODE: begin
               next_rdata[arf_pkg::MODE_SLEEP] = sleep_mode;
            end
            arf_pkg::OFS_CHSR: begin
               next_rdata[N_CHAN-1:0] = o_chan_en;
            end
            arf_pkg::OFS_STATUS: begin
               next_rdata = status_word;
            end
            arf_pkg::OFS_LAST: begin
               next_rdata[DATA_W-1:0] = last_data;
               next_rdata[arf_pkg::LAST_CH_LSB +: CW] = last_chan;
            end
            arf_pkg::OFS_INT_STAT: begin
               next_rdata[arf_pkg::INT_W-1:0] = int_stat;
            end
            arf_pkg::OFS_INT_EN: begin
               next_rdata[arf_pkg::INT_W-1:0] = int_en;
            end
            default: begin
               next_rdata = arf_pkg::RST_WORD;
            end
         endcase
      end
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= arf_pkg::RST_WORD;
      end else if (i_ce) begin
         o_rdata <= rd_q ? next_rdata : arf_pkg::RST_WORD;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   data_ready_flag_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
      rd_last && !store |=> !data_ready_flag) else $error("data ready not cleared");
   data_ready_flag_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
      data_ready_flag && !rd_last |=> data_ready_flag) else $error("data ready lost");
   store_last_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
      store |=> data_ready_flag && (last_data == $past(i_eoc_data)) && (last_chan == $past(i_eoc_chan)))
      else $error("store not taken");
   data_ready_flag_noset_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R3
      !data_ready_flag && !store |=> !data_ready_flag) else $error("data ready without store");
   govr_set_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
      store && data_ready_flag |=> govr) else $error("general overrun missed");
   govr_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R6
      rd_stat && !new_govr |=> !govr) else $error("general overrun kept");
   no_dead_done_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R12
      eoc_v && !chan_ok |=> (done & ~$past(done)) == '0) else $error("done on dead channel");
   one_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R11
      rd_q && is_cdr && !rd_last && !store |=> (($past(done) & ~done) & ~$past(rd_cdr)) == '0)
      else $error("wrong done cleared");
   sleep_entry_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R13
      eoc_v && sleep_mode && !o_conv_start ##1 i_ce && sleep_mode && !o_conv_start |=> o_sleep)
      else $error("sleep not entered");
   int_win_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R14
      int_evt[arf_pkg::INT_STORE] |=> int_stat[arf_pkg::INT_STORE])
      else $error("event lost to clear");
   // a low enable must freeze every flag, or a stalled bus would still lose events
   freeze_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !i_ce |=> $stable(data_ready_flag) && $stable(govr) && $stable(done) && $stable(ovr)
         && $stable(int_stat) && $stable(o_chan_en) && $stable(o_rdata))
      else $error("state moved while frozen");
   // read data stand one cycle only, so a late sampler sees zero, not stale data
   rdata_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_ce && !rd_q |=> o_rdata == arf_pkg::RST_WORD) else $error("read data left standing");
   irq_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_ce |=> o_irq == |($past(int_stat & int_en))) else $error("interrupt out of step");
   govr_cross_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R7
      store && data_ready_flag && (rd_q || wr_q) |=> govr) else $error("general overrun lost to access");
   dis_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R12
      wr_q && (i_addr == arf_pkg::OFS_CHDIS)
      |=> (o_chan_en & $past(i_wdata[N_CHAN-1:0])) == '0) else $error("channel not disabled");
   sleep_wake_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R13
      i_ce && (o_conv_start || !sleep_mode) |=> !o_sleep) else $error("sleep not left");
endmodule

// ==== inc/arf_pkg.sv ====
// arf_pkg: register map, field positions and reset values of the adc result/status flag block
// assumes: byte addresses on an 8-bit register port, 32-bit data, one word per register
package arf_pkg;
   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int          NUM_CHAN     = 4;
   localparam int          DATA_W       = 10;
   localparam int          ADDR_W       = 8;
   localparam int          BUS_W        = 32;
   localparam int          INT_W        = 3;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_MODE     = 8'h04;
   localparam logic [7:0]  OFS_CHEN     = 8'h10;
   localparam logic [7:0]  OFS_CHDIS    = 8'h14;
   localparam logic [7:0]  OFS_CHSR     = 8'h18;
   localparam logic [7:0]  OFS_STATUS   = 8'h1c;
   localparam logic [7:0]  OFS_LAST     = 8'h20;
   localparam logic [7:0]  OFS_INT_STAT = 8'h24;
   localparam logic [7:0]  OFS_INT_CLR  = 8'h28;
   localparam logic [7:0]  OFS_INT_EN   = 8'h2c;
   // channel result registers sit at 0x30 + 4*channel
   localparam logic [3:0]  CDR_PAGE     = 4'h3;
   localparam int          CDR_IDX_LSB  = 2;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int          CTRL_START   = 0;
   localparam int          MODE_SLEEP   = 0;
   localparam int          ST_DONE_LSB  = 0;
   localparam int          ST_OVR_LSB   = 8;
   localparam int          ST_DATA_READY_FLAG      = 16;
   localparam int          ST_GOVR      = 17;
   localparam int          LAST_CH_LSB  = 12;
   localparam int          INT_STORE    = 0;
   localparam int          INT_GOVR     = 1;
   localparam int          INT_OVR      = 2;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [31:0] RST_WORD     = 32'h0000_0000;
   localparam logic        RST_BIT      = 1'b0;
endpackage

// ==== design/arf_chan_cell.sv ====
// arf_chan_cell: one channel's result register, conversion-done flag and overrun flag
// assumes: strobes are single-cycle qualified pulses on i_ref_clk, already gated by the enable
`timescale 1ns/1ps
module arf_chan_cell #(
   parameter int DATA_W = arf_pkg::DATA_W
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst,
   input  wire logic              i_store,
   input  wire logic              i_hit,
   input  wire logic [DATA_W-1:0] i_data,
   input  wire logic              i_rd_clear,
   input  wire logic              i_stat_rd,
   output logic                   o_done,
   output logic                   o_ovr,
   output logic [DATA_W-1:0]      o_result,
   output logic                   o_ovr_set
);
   // ------------------------------------------------------------
   // result and flags
   // ------------------------------------------------------------
   // R8: overrun on unread result
   assign o_ovr_set = i_hit && o_done;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_result <= '0;
      end else if (i_store) begin
         o_result <= i_data;
      end
   end

   // R10: read clears done
   // R14: store beats clear
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_done <= arf_pkg::RST_BIT;
      end else if (i_store) begin
         o_done <= 1'b1;
      end else if (i_rd_clear) begin
         o_done <= 1'b0;
      end
   end

   // R9: status read clears overrun
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ovr <= arf_pkg::RST_BIT;
      end else if (o_ovr_set) begin
         o_ovr <= 1'b1;
      end else if (i_stat_rd) begin
         o_ovr <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   ovr_set_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R8
      o_ovr_set |=> o_ovr) else $error("overrun not raised");
   ovr_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R9
      i_stat_rd && !o_ovr_set |=> !o_ovr) else $error("overrun not cleared");
   done_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R10
      i_rd_clear && !i_store |=> !o_done) else $error("done not cleared");
endmodule

// ==== test/arf_flags_bench.sv ====
// arf_flags_bench: self-checking bench for the adc result and status flag block
// assumes: the bench plays both software and converter core on the one clock
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module arf_flags_bench;
   // ----------------------------------------------------------
   // signals
   // ----------------------------------------------------------
   logic        i_ref_clk;
   logic        i_rst;
   logic        i_ce;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [31:0] o_rdata;
   logic        i_eoc;
   logic [1:0]  i_eoc_chan;
   logic [9:0]  i_eoc_data;
   logic        o_conv_start;
   logic [3:0]  o_chan_en;
   logic        o_sleep;
   logic        o_irq;
   logic [31:0] rdat;
   int          n_fail;
   int          samples_checked;
   localparam logic [7:0] ST = arf_pkg::OFS_STATUS;
   localparam logic [7:0] LR = arf_pkg::OFS_LAST;
   localparam logic [7:0] CD = 8'h30;

   arf_flags i_dut (
      .i_ref_clk    (i_ref_clk),
      .i_rst        (i_rst),
      .i_ce         (i_ce),
      .i_addr       (i_addr),
      .i_wdata      (i_wdata),
      .i_wr         (i_wr),
      .i_rd         (i_rd),
      .o_rdata      (o_rdata),
      .i_eoc        (i_eoc),
      .i_eoc_chan   (i_eoc_chan),
      .i_eoc_data   (i_eoc_data),
      .o_conv_start (o_conv_start),
      .o_chan_en    (o_chan_en),
      .o_sleep      (o_sleep),
      .o_irq        (o_irq)
   );

   // ----------------------------------------------------------
   // clock and drivers
   // ----------------------------------------------------------
   initial begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end

   // one bus cycle, optionally with an end of conversion in the same cycle;
   // read data is taken in the cycle after the strobe, the only place it stands
   task automatic cyc(input logic r, input logic w, input logic [7:0] a,
                      input logic [31:0] wd, input logic e, input logic [1:0] ch,
                      input logic [9:0] dt);
      @(posedge i_ref_clk);
      i_rd       <= r;
      i_wr       <= w;
      i_addr     <= a;
      i_wdata    <= wd;
      i_eoc      <= e;
      i_eoc_chan <= ch;
      i_eoc_data <= dt;
      @(posedge i_ref_clk);
      i_rd       <= 1'b0;
      i_wr       <= 1'b0;
      i_eoc      <= 1'b0;
      #1 rdat = o_rdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cyc(1'b0, 1'b1, a, d, 1'b0, 2'h0, 10'h000);
   endtask

   task automatic rd(input logic [7:0] a);
      cyc(1'b1, 1'b0, a, 32'h0000_0000, 1'b0, 2'h0, 10'h000);
   endtask

   task automatic ev(input logic [1:0] ch, input logic [9:0] dt);
      cyc(1'b0, 1'b0, 8'h00, 32'h0000_0000, 1'b1, ch, dt);
   endtask

   task automatic stop_test;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // a hang costs far more than the roughly 120 cycles the tests need
   initial begin
      #400000;
      n_fail++;
      stop_test();
   end

   // ----------------------------------------------------------
   // tests
   // ----------------------------------------------------------
   initial begin
      n_fail = 0;
      samples_checked = 0;
      i_rst = 1'b1;
      i_ce = 1'b1;
      i_addr = 8'h00;
      i_wdata = 32'h0000_0000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_eoc = 1'b0;
      i_eoc_chan = 2'h0;
      i_eoc_data = 10'h000;
      repeat (5) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      rd(ST); `CHK("status rst", 32'h0000_0000, rdat)
      wr(arf_pkg::OFS_CHEN, 32'h0000_000f);
      rd(arf_pkg::OFS_CHSR); `CHK("chsr", 32'h0000_000f, rdat)
      // store, then channel read keeps data ready, last read clears it
      ev(2'h1, 10'h155);
      rd(CD + 8'h04); `CHK("cdr1", 32'h0000_0155, rdat)
      rd(ST); `CHK("st cdr read", 32'h0001_0000, rdat)
      rd(LR); `CHK("last", 32'h0000_1155, rdat)
      rd(ST); `CHK("st last read", 32'h0000_0000, rdat)
      // back to back stores on one channel
      ev(2'h2, 10'h0aa);
      ev(2'h2, 10'h0ab);
      rd(ST); `CHK("st ovr", 32'h0003_0404, rdat)
      rd(ST); `CHK("st ovr clr", 32'h0001_0004, rdat)
      rd(LR); `CHK("last2", 32'h0000_20ab, rdat)
      // status read beside a store that makes no new overrun
      ev(2'h0, 10'h001);
      ev(2'h0, 10'h002);
      rd(LR); `CHK("last0", 32'h0000_0002, rdat)
      cyc(1'b1, 1'b0, ST, 32'h0, 1'b1, 2'h0, 10'h003);
      `CHK("st snap", 32'h0002_0100, rdat)
      rd(ST); `CHK("st after", 32'h0001_0001, rdat)
      // status read beside a store that is a new general overrun
      cyc(1'b1, 1'b0, ST, 32'h0, 1'b1, 2'h3, 10'h004);
      rd(ST); `CHK("st govr", 32'h0003_0009, rdat)
      rd(LR); `CHK("last3", 32'h0000_3004, rdat)
      rd(CD); `CHK("cdr0", 32'h0000_0003, rdat)
      // channel read of another channel beside a store
      ev(2'h0, 10'h005);
      cyc(1'b1, 1'b0, CD + 8'h04, 32'h0, 1'b1, 2'h2, 10'h006);
      `CHK("cdr1 again", 32'h0000_0155, rdat)
      rd(ST); `CHK("st cross", 32'h0003_0005, rdat)
      rd(LR);
      rd(CD);
      // disable of another channel beside a store
      ev(2'h1, 10'h007);
      cyc(1'b0, 1'b1, arf_pkg::OFS_CHDIS, 32'h8, 1'b1, 2'h1, 10'h3ff);
      rd(ST); `CHK("st dis", 32'h0003_0202, rdat)
      rd(arf_pkg::OFS_CHSR); `CHK("chsr dis", 32'h0000_0007, rdat)
      rd(CD + 8'h04); `CHK("cdr1 dis", 32'h0000_03ff, rdat)
      // conversion end on a disabled channel beside a last read
      cyc(1'b1, 1'b0, LR, 32'h0, 1'b1, 2'h3, 10'h111);
      `CHK("last dis", 32'h0000_13ff, rdat)
      cyc(1'b0, 1'b1, arf_pkg::OFS_CHDIS, 32'h4, 1'b1, 2'h2, 10'h222);
      rd(ST); `CHK("st none", 32'h0000_0000, rdat)
      rd(CD + 8'h0c); `CHK("cdr3", 32'h0000_0004, rdat)
      rd(CD + 8'h08); `CHK("cdr2", 32'h0000_0006, rdat)
      // interrupt enable, clear, raise and mask
      wr(arf_pkg::OFS_INT_EN, 32'h7);
      rd(arf_pkg::OFS_INT_EN); `CHK("int en", 32'h0000_0007, rdat)
      `CHK("irq on", 1'b1, o_irq)
      rd(arf_pkg::OFS_INT_STAT); `CHK("int stat", 32'h0000_0007, rdat)
      wr(arf_pkg::OFS_INT_CLR, 32'h7);
      rd(arf_pkg::OFS_INT_STAT); `CHK("int clr", 32'h0000_0000, rdat)
      `CHK("irq off", 1'b0, o_irq)
      ev(2'h0, 10'h010);
      rd(arf_pkg::OFS_INT_STAT); `CHK("int store", 32'h0000_0001, rdat)
      `CHK("irq store", 1'b1, o_irq)
      wr(arf_pkg::OFS_INT_EN, 32'h0);
      @(posedge i_ref_clk);
      #1 `CHK("irq mask", 1'b0, o_irq)
      rd(8'hfc); `CHK("unmapped", 32'h0000_0000, rdat)
      `CHK("chan en", 4'h3, o_chan_en)
      // a frozen block ignores the bus
      @(posedge i_ref_clk);
      i_ce <= 1'b0;
      wr(arf_pkg::OFS_INT_EN, 32'h7);
      @(posedge i_ref_clk);
      i_ce <= 1'b1;
      rd(arf_pkg::OFS_INT_EN); `CHK("ce frozen", 32'h0000_0000, rdat)
      `CHK("irq frozen", 1'b0, o_irq)
      // sleep waits for the end of a conversion
      wr(arf_pkg::OFS_MODE, 32'h1);
      rd(arf_pkg::OFS_MODE); `CHK("mode", 32'h0000_0001, rdat)
      `CHK("no sleep yet", 1'b0, o_sleep)
      wr(arf_pkg::OFS_CTRL, 32'h1);
      `CHK("start", 1'b1, o_conv_start)
      @(posedge i_ref_clk);
      #1 `CHK("start end", 1'b0, o_conv_start)
      ev(2'h0, 10'h011);
      `CHK("sleep", 1'b1, o_sleep)
      wr(arf_pkg::OFS_MODE, 32'h0);
      @(posedge i_ref_clk);
      #1 `CHK("wake", 1'b0, o_sleep)
      stop_test();
   end
endmodule
